// ===== src/adss_map.vh
/*
  Offsets, field positions, reset values and timing counts of the converter
  selection and sleep sequencer. Assumes inclusion by adss_sequencer.v and by the verification files.
*/
`ifndef ADSS_MAP_VH
`define ADSS_MAP_VH

// ********************************************************************
// register byte addresses
// ********************************************************************
`define ADSS_SEL_ADDR      8'h00
`define ADSS_CTRL_ADDR     8'h04
`define ADSS_RESL_ADDR     8'h08
`define ADSS_RESH_ADDR     8'h0C

// ********************************************************************
// selection register fields
// ********************************************************************
`define ADSS_SEL_REF_HI    7
`define ADSS_SEL_REF_LO    6
`define ADSS_SEL_LADJ      5
`define ADSS_SEL_CHAN_HI   3
`define ADSS_SEL_CHAN_LO   0
`define ADSS_SEL_RESET     8'h00

// ********************************************************************
// control and status register fields
// ********************************************************************
`define ADSS_CTRL_EN       7
`define ADSS_CTRL_START    6
`define ADSS_CTRL_FREE     5
`define ADSS_CTRL_DONE     4
`define ADSS_CTRL_IE       3
`define ADSS_CTRL_PS_HI    2
`define ADSS_CTRL_PS_LO    0

// ********************************************************************
// reference choices
// ********************************************************************
`define ADSS_REF_EXTPIN    2'b00
`define ADSS_REF_SUPPLY    2'b01
`define ADSS_REF_BANDGAP   2'b11

// ********************************************************************
// conversion timing in converter clock cycles, and SAR code values
// ********************************************************************
`define ADSS_CYC_NORMAL    5'd13
`define ADSS_CYC_FIRST     5'd25
`define ADSS_SAR_BITS      5'd11
`define ADSS_FULL_SCALE    10'h3FF
`define ADSS_SAR_MSB       10'h200

`endif

// ===== src/adss_sequencer.v
/*
  Selection buffering, start timing, free-running and sleep-start sequencing
  of a 10-bit successive-approximation converter, with an AHB-Lite register
  slave. Assumes one 100 MHz clock, an external analog comparator that reports
  whether the selected input is at or above the trial level, and a processor
  that reports halting in idle or noise-reduction sleep and acknowledges the
  completion interrupt vector.
  Assumes too a bus master that makes single word transfers with the register
  data in the low byte, ties hready to hreadyout, and reads the result low
  byte before the high byte when it wants both halves of one conversion.
*/
// Local design decisions: the AHB-Lite slave port and the placing of the registers.
`include "adss_map.vh"

module adss_sequencer (
  input  wire        clock,
  input  wire        resetn,
  input  wire        hsel,
  input  wire [7:0]  haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire        hreadyout,
  output wire        hresp,
  output reg  [31:0] hrdata,
  input  wire        cpuHaltedQuiet,
  input  wire        irqVectorAck,
  input  wire        compareHigh,
  output reg  [3:0]  channelSelect,
  output reg  [1:0]  referenceSelect,
  output wire        converterPowered,
  output wire        sampleHold,
  output wire [9:0]  trialCode,
  output wire        completionIrq
);

  // ********************************************************************
  // functions
  // ********************************************************************
  // division factor of the converter clock prescaler, minus one
  function [6:0] divLimit;
    input [2:0] ps;
    begin
      if (ps == 3'd0)
        divLimit = 7'd1;
      else
        divLimit = (7'd1 << ps) - 7'd1;
    end
  endfunction

  // 16-bit presentation of a result, right or left adjusted
  function [15:0] presentResult;
    input [9:0] res;
    input       ladj;
    begin
      if (ladj)
        presentResult = {res, 6'd0};
      else
        presentResult = {6'd0, res};
    end
  endfunction

  // read of one register, decided in the address phase
  function readOf;
    input [7:0] addr;
    input [7:0] offset;
    input       taken;
    input       isWrite;
    begin
      readOf = taken & ~isWrite & (addr == offset);
    end
  endfunction

  // ********************************************************************
  // state
  // ********************************************************************
  localparam IDLE = 1'b0;
  localparam CONV = 1'b1;

  reg        state;
  reg [7:0]  selBuffer;
  reg        enable;
  reg        freeRun;
  reg        intEnable;
  reg [2:0]  prescale;
  reg        doneFlag;
  reg        startReq;
  reg        needInit;
  reg [6:0]  divCount;
  reg [4:0]  cycle;
  reg [4:0]  cycleTotal;
  reg [9:0]  sarCode;
  reg [9:0]  trialBit;
  reg [9:0]  result;
  reg        resultLock;
  reg        haltedLast;
  reg        dataPhase;
  reg        dataWrite;
  reg [7:0]  dataAddr;
  reg [31:0] next_hrdata;

  wire        accept    = hsel & htrans[1] & hready;
  wire        writeSel  = dataPhase & dataWrite & (dataAddr == `ADSS_SEL_ADDR);
  wire        writeCtrl = dataPhase & dataWrite & (dataAddr == `ADSS_CTRL_ADDR);
  // at or above the limit, so a smaller division factor never waits a wrap
  wire        convTick  = enable & (divCount >= divLimit(prescale));
  wire        busy      = (state == CONV);
  wire        lastCycle = busy & (cycle == cycleTotal);
  wire        completes = lastCycle & convTick;
  wire        sleepTrig = cpuHaltedQuiet & ~haltedLast;
  wire [15:0] shown     = presentResult(result, selBuffer[`ADSS_SEL_LADJ]);
  wire        startWr   = writeCtrl & hwdata[`ADSS_CTRL_START] & hwdata[`ADSS_CTRL_EN];
  wire        sleepGo   = sleepTrig & enable & ~busy & ~startReq & ~freeRun & intEnable;
  wire        startShown = startReq | busy;
  wire        doneClear  = writeCtrl & hwdata[`ADSS_CTRL_DONE];

  // ********************************************************************
  // bus response and converter pins
  // ********************************************************************
  assign hreadyout        = 1'b1;
  assign hresp            = 1'b0;
  assign converterPowered = enable;
  assign sampleHold       = busy & (cycle > cycleTotal - `ADSS_SAR_BITS);
  assign trialCode        = sarCode;
  assign completionIrq    = doneFlag & intEnable;

  // ********************************************************************
  // bus address phase capture and read data
  // ********************************************************************
  always @* begin
    case (haddr)
      `ADSS_SEL_ADDR:
        next_hrdata = {24'd0, selBuffer[7:5], 1'b0, selBuffer[3:0]};
      `ADSS_CTRL_ADDR:
        next_hrdata = {24'd0, enable, startShown, freeRun, doneFlag,
                       intEnable, prescale};
      `ADSS_RESL_ADDR:
        next_hrdata = {24'd0, shown[7:0]};
      `ADSS_RESH_ADDR:
        next_hrdata = {24'd0, shown[15:8]};
      default:
        next_hrdata = 32'h0000_0000;
    endcase
  end

  always @(posedge clock) begin
    if (!resetn) begin
      dataPhase <= 1'b0;
      dataWrite <= 1'b0;
      dataAddr  <= 8'h00;
      hrdata    <= 32'h0000_0000;
    end else begin
      if (hready) begin
        dataPhase <= accept;
        dataWrite <= hwrite;
        dataAddr  <= haddr;
      end
      if (accept && !hwrite)
        hrdata <= next_hrdata;
    end
  end

  // ********************************************************************
  // software fields
  // ********************************************************************
  always @(posedge clock) begin
    if (!resetn) begin
      selBuffer <= `ADSS_SEL_RESET;
      enable    <= 1'b0;
      freeRun   <= 1'b0;
      intEnable <= 1'b0;
      prescale  <= 3'd0;
    end else begin
      if (writeSel)
        selBuffer <= hwdata[7:0];
      // no automatic disable on any sleep entry
      if (writeCtrl) begin
        enable    <= hwdata[`ADSS_CTRL_EN];
        freeRun   <= hwdata[`ADSS_CTRL_FREE];
        intEnable <= hwdata[`ADSS_CTRL_IE];
        prescale  <= hwdata[`ADSS_CTRL_PS_HI:`ADSS_CTRL_PS_LO];
      end
    end
  end

  // ********************************************************************
  // converter clock prescaler, held in reset while disabled
  // ********************************************************************
  always @(posedge clock) begin
    if (!resetn || !enable || convTick)
      divCount <= 7'd0;
    else
      divCount <= divCount + 7'd1;
  end

  // ********************************************************************
  // active selection
  // ********************************************************************
  always @(posedge clock) begin
    if (!resetn) begin
      channelSelect   <= 4'd0;
      referenceSelect <= `ADSS_REF_EXTPIN;
    // frozen mid-conversion so the sampled input stays put
    end else if (enable && (!busy || lastCycle)) begin
      channelSelect   <= selBuffer[`ADSS_SEL_CHAN_HI:`ADSS_SEL_CHAN_LO];
      referenceSelect <= selBuffer[`ADSS_SEL_REF_HI:`ADSS_SEL_REF_LO];
    end
  end

  // ********************************************************************
  // sleep trigger
  // ********************************************************************
  // cleared to the idle level of the halt input, so reset makes no edge
  always @(posedge clock) begin
    if (!resetn)
      haltedLast <= 1'b0;
    else
      haltedLast <= cpuHaltedQuiet;
  end

  // ********************************************************************
  // start request
  // ********************************************************************
  always @(posedge clock) begin
    if (!resetn)
      startReq <= 1'b0;
    else if (startWr || sleepGo)
      startReq <= 1'b1;
    else if (!enable || (convTick && !busy))
      startReq <= 1'b0;
  end

  // ********************************************************************
  // done flag; the hardware set wins over both clears
  // ********************************************************************
  always @(posedge clock) begin
    if (!resetn)
      doneFlag <= 1'b0;
    else if (completes)
      doneFlag <= 1'b1;
    else if (irqVectorAck || doneClear)
      doneFlag <= 1'b0;
  end

  // ********************************************************************
  // conversion sequencer
  // ********************************************************************
  always @(posedge clock) begin
    if (!resetn) begin
      state      <= IDLE;
      needInit   <= 1'b1;
      cycle      <= 5'd0;
      cycleTotal <= `ADSS_CYC_NORMAL;
      sarCode    <= 10'd0;
      trialBit   <= 10'd0;
    end else if (!enable) begin
      // disabling aborts any conversion
      state    <= IDLE;
      needInit <= 1'b1;
      cycle    <= 5'd0;
      trialBit <= 10'd0;
    end else if (convTick) begin
      case (state)
        IDLE: begin
          if (startReq) begin
            state      <= CONV;
            cycle      <= 5'd1;
            cycleTotal <= needInit ? `ADSS_CYC_FIRST : `ADSS_CYC_NORMAL;
            needInit   <= 1'b0;
          end
        end
        CONV: begin
          if (cycle == cycleTotal) begin
            // free run restarts at once with the selection copied in the last cycle
            if (freeRun) begin
              cycle      <= 5'd1;
              cycleTotal <= `ADSS_CYC_NORMAL;
            end else begin
              state <= IDLE;
              cycle <= 5'd0;
            end
          end else begin
            cycle <= cycle + 5'd1;
          end
          if (cycle == cycleTotal - `ADSS_SAR_BITS) begin
            sarCode  <= `ADSS_SAR_MSB;
            trialBit <= `ADSS_SAR_MSB;
          end else if (trialBit != 10'd0) begin
            // keep the trial bit while the input is at or above it
            sarCode  <= (compareHigh ? sarCode : (sarCode & ~trialBit))
                        | (trialBit >> 1);
            trialBit <= trialBit >> 1;
          end
        end
        default: state <= IDLE;
      endcase
    end
  end

  // ********************************************************************
  // result and result lock registers
  // ********************************************************************
  always @(posedge clock) begin
    if (!resetn) begin
      result     <= 10'd0;
      resultLock <= 1'b0;
    end else begin
      if (completes && !resultLock)
        result <= sarCode;
      // low byte read blocks updates until the high byte is read
      if (readOf(haddr, `ADSS_RESL_ADDR, accept, hwrite))
        resultLock <= 1'b1;
      else if (readOf(haddr, `ADSS_RESH_ADDR, accept, hwrite))
        resultLock <= 1'b0;
    end
  end

  // start bit reads busy or pending; it drops with the single completion
  // because startReq already fell at the starting tick and busy falls at the completing tick

endmodule

// ===== verif/adss_sequencer_chk.sv
/*
  Port checker for the converter selection and sleep sequencer.
  Assumes it is bound to adss_sequencer and sees its ports only.
*/
`include "adss_map.vh"
module adss_sequencer_chk (
  input wire logic        clock,
  input wire logic        resetn,
  input wire logic        hsel,
  input wire logic [7:0]  haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  input wire logic        irqVectorAck,
  input wire logic [3:0]  channelSelect,
  input wire logic        converterPowered,
  input wire logic        sampleHold,
  input wire logic [9:0]  trialCode,
  input wire logic        completionIrq
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // data phase tracking
  // ****************************************
  logic       dPh;
  logic       dWr;
  logic [7:0] dAd;
  wire        ctlWr  = dPh & dWr & (dAd == `ADSS_CTRL_ADDR);
  wire        mapped = (dAd[7:4] == 4'h0) & (dAd[1:0] == 2'h0);
  always @(posedge clock) begin
    if (!resetn) begin
      dPh <= 1'b0;
      dWr <= 1'b0;
      dAd <= 8'h00;
    end else begin
      dPh <= hsel & htrans[1] & hready;
      dWr <= hwrite;
      dAd <= haddr;
    end
  end
  // ****************************************
  // assertions
  // ****************************************
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus answer not zero-wait okay");
  rd_upper_a: assert property (dPh && !dWr |-> hrdata[31:8] == 24'h00_0000)
    else $error("read data upper bits not zero");
  rd_unmapped_a: assert property (dPh && !dWr && !mapped |-> hrdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  pow_follow_a: assert property (ctlWr |=> converterPowered == $past(hwdata[7]))
    else $error("power does not follow enable write");
  pow_hold_a: assert property (!ctlWr |=> $stable(converterPowered))
    else $error("power changed without enable write");
  chan_pow_a: assert property ($changed(channelSelect) |-> $past(converterPowered))
    else $error("channel copied while disabled");
  ack_clear_a: assert property (irqVectorAck && !sampleHold |=> !completionIrq)
    else $error("vector ack left request high");
  irq_fall_a: assert property ($fell(completionIrq) |-> $past(irqVectorAck) || $past(ctlWr))
    else $error("request dropped without cause");
  reset_vals_a: assert property ($rose(resetn) |-> hrdata == 32'h0000_0000 && !completionIrq && !converterPowered && channelSelect == 4'h0 && trialCode == 10'h000)
    else $error("outputs not at reset values");
endmodule

bind adss_sequencer adss_sequencer_chk chk_u (.clock(clock), .resetn(resetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irqVectorAck(irqVectorAck),
  .channelSelect(channelSelect), .converterPowered(converterPowered), .sampleHold(sampleHold),
  .trialCode(trialCode), .completionIrq(completionIrq));

// ===== verif/adss_analog_model.sv
/*
  Analog inputs, references and comparator facing the sequencer.
  Assumes the bench sets channel voltages in millivolts.
*/
`include "adss_map.vh"
module adss_analog_model #(
  parameter int SUPPLY_MV = 5000,
  parameter int EXT_MV    = 4000
) (
  input  wire logic       clock,
  input  wire logic [3:0] channelSelect,
  input  wire logic [1:0] referenceSelect,
  input  wire logic [9:0] trialCode,
  input  wire logic       sampleHold,
  input  wire logic       converterPowered,
  output logic            compareHigh
);
  timeunit 1ns;
  timeprecision 1ps;
  int   vinMv [16];
  int   vrefMv;
  logic wobble = 1'b0;
  always @(posedge clock) wobble <= ~wobble;
  always_comb begin
    case (referenceSelect)
      `ADSS_REF_SUPPLY:  vrefMv = SUPPLY_MV;
      `ADSS_REF_BANDGAP: vrefMv = 2560;
      default:           vrefMv = EXT_MV;
    endcase
  end
  // outside sampling the comparator output is meaningless, so it wanders
  assign compareHigh = (converterPowered && sampleHold) ?
    (vinMv[channelSelect] * 1024 >= int'(trialCode) * vrefMv) : wobble;
endmodule

// ===== verif/adss_sequencer_test.sv
/*
  Self-checking bench for the converter selection and sleep sequencer.
  Assumes the analog model as comparator and the bound port checker.
*/
`include "adss_map.vh"
module adss_sequencer_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SUPPLY_MV = 5000;
  localparam int EXT_MV    = 4000;
  logic        clock = 1'b0;
  logic        resetn = 1'b0;
  logic        hsel = 1'b0;
  logic [7:0]  haddr = 8'h00;
  logic [1:0]  htrans = 2'b00;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic        cpuHaltedQuiet = 1'b0;
  logic        irqVectorAck = 1'b0;
  wire         hreadyout, hresp, compareHigh, converterPowered, sampleHold, completionIrq;
  wire  [31:0] hrdata;
  wire  [3:0]  channelSelect;
  wire  [1:0]  referenceSelect;
  wire  [9:0]  trialCode;
  int          error_cnt = 0;
  int          n_compared = 0;
  int          cyc = 0;
  logic [31:0] q;
  logic [9:0]  res;

  adss_sequencer dut_u (.clock(clock), .resetn(resetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .cpuHaltedQuiet(cpuHaltedQuiet),
    .irqVectorAck(irqVectorAck), .compareHigh(compareHigh), .channelSelect(channelSelect),
    .referenceSelect(referenceSelect), .converterPowered(converterPowered),
    .sampleHold(sampleHold), .trialCode(trialCode), .completionIrq(completionIrq));
  adss_analog_model #(.SUPPLY_MV(SUPPLY_MV), .EXT_MV(EXT_MV)) ana_u (.clock(clock),
    .channelSelect(channelSelect), .referenceSelect(referenceSelect), .trialCode(trialCode),
    .sampleHold(sampleHold), .converterPowered(converterPowered), .compareHigh(compareHigh));

  // ****************************************
  // shared tasks
  // ****************************************
  initial forever #5 clock = ~clock;
  always @(posedge clock) cyc <= cyc + 1;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'b10;
    do @(posedge clock); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h00_0000, d};
    do @(posedge clock); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic waitDone();
    for (int n = 0; n < 400; n++) begin
      bus(1'b0, `ADSS_CTRL_ADDR, 8'h00);
      if (q[`ADSS_CTRL_DONE] === 1'b1) break;
    end
    chk(q[`ADSS_CTRL_DONE], 1);
  endtask
  task automatic readRes();
    bus(1'b0, `ADSS_RESL_ADDR, 8'h00);
    res[7:0] = q[7:0];
    bus(1'b0, `ADSS_RESH_ADDR, 8'h00);
    res[9:8] = q[1:0];
  endtask
  function automatic logic [9:0] code(input int mv, input int vr);
    int c = mv * 1024 / vr;
    return (c > 1023) ? 10'h3FF : c[9:0];
  endfunction
  task automatic test_done();
    $display("errors %0d compared %0d", error_cnt, n_compared);
    if (error_cnt == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    logic [7:0] a[5] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10};
    for (int i = 0; i < 5; i++) begin
      bus(1'b0, a[i], 8'h00);
      chk(q, 0);
    end
  endtask
  task automatic t_single();
    int c0;
    ana_u.vinMv[1] = 1250;
    bus(1'b1, `ADSS_SEL_ADDR, 8'h41);
    bus(1'b1, `ADSS_CTRL_ADDR, 8'hCA);
    c0 = cyc;
    bus(1'b0, `ADSS_CTRL_ADDR, 8'h00);
    chk(q[`ADSS_CTRL_START], 1);
    chk(channelSelect, 1);
    waitDone();
    chk(cyc - c0 >= 100 && cyc - c0 <= 108, 1);
    chk(q[`ADSS_CTRL_START], 0);
    chk(completionIrq, 1);
    readRes();
    chk(res, code(1250, SUPPLY_MV));
    bus(1'b1, `ADSS_CTRL_ADDR, 8'h9A);
    @(posedge clock);
    chk(completionIrq, 0);
  endtask
  task automatic t_lock();
    int c0;
    ana_u.vinMv[2] = 3000;
    ana_u.vinMv[3] = 500;
    bus(1'b1, `ADSS_SEL_ADDR, 8'h42);
    bus(1'b1, `ADSS_CTRL_ADDR, 8'hCA);
    c0 = cyc;
    repeat (12) @(posedge clock);
    bus(1'b1, `ADSS_SEL_ADDR, 8'h43);
    repeat (2) @(posedge clock);
    chk(channelSelect, 2);
    waitDone();
    chk(cyc - c0 >= 52 && cyc - c0 <= 60, 1);
    chk(channelSelect, 3);
    readRes();
    chk(res, code(3000, SUPPLY_MV));
    bus(1'b1, `ADSS_CTRL_ADDR, 8'h9A);
    bus(1'b1, `ADSS_CTRL_ADDR, 8'hCA);
    waitDone();
    readRes();
    chk(res, code(500, SUPPLY_MV));
    bus(1'b1, `ADSS_CTRL_ADDR, 8'h9A);
  endtask
  task automatic t_refs();
    logic [1:0] r[3] = '{`ADSS_REF_EXTPIN, `ADSS_REF_SUPPLY, `ADSS_REF_BANDGAP};
    int v[3] = '{EXT_MV, SUPPLY_MV, 2560};
    ana_u.vinMv[4] = 3000;
    for (int i = 0; i < 3; i++) begin
      bus(1'b1, `ADSS_SEL_ADDR, {r[i], 6'h04});
      bus(1'b1, `ADSS_CTRL_ADDR, 8'hCA);
      waitDone();
      bus(1'b1, `ADSS_CTRL_ADDR, 8'h9A);
      bus(1'b1, `ADSS_CTRL_ADDR, 8'hCA);
      waitDone();
      chk(referenceSelect, r[i]);
      readRes();
      chk(res, code(3000, v[i]));
      bus(1'b1, `ADSS_CTRL_ADDR, 8'h9A);
    end
  endtask
  task automatic t_sleep();
    ana_u.vinMv[0] = 1000;
    bus(1'b1, `ADSS_SEL_ADDR, 8'h40);
    bus(1'b1, `ADSS_CTRL_ADDR, 8'h8A);
    cpuHaltedQuiet <= 1'b1;
    waitDone();
    chk(completionIrq, 1);
    chk(converterPowered, 1);
    irqVectorAck <= 1'b1;
    @(posedge clock);
    irqVectorAck <= 1'b0;
    cpuHaltedQuiet <= 1'b0;
    @(posedge clock);
    chk(completionIrq, 0);
    readRes();
    chk(res, code(1000, SUPPLY_MV));
  endtask
  task automatic t_free();
    ana_u.vinMv[5] = 4000;
    bus(1'b1, `ADSS_CTRL_ADDR, 8'hE2);
    waitDone();
    bus(1'b1, `ADSS_SEL_ADDR, 8'h45);
    bus(1'b1, `ADSS_CTRL_ADDR, 8'hB2);
    waitDone();
    readRes();
    chk(res, code(1000, SUPPLY_MV));
    bus(1'b1, `ADSS_CTRL_ADDR, 8'hB2);
    waitDone();
    readRes();
    chk(res, code(4000, SUPPLY_MV));
    bus(1'b1, `ADSS_CTRL_ADDR, 8'h00);
  endtask

  initial begin
    repeat (20000) @(posedge clock);
    error_cnt++;
    test_done();
  end
  initial begin
    repeat (8) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    t_reset();
    t_single();
    t_lock();
    t_refs();
    t_sleep();
    t_free();
    test_done();
  end
endmodule
